// [logic/t1rs_pkg.sv]
`default_nettype none
package t1rs_pkg;
  // line framing geometry
  localparam logic [7:0] BIT_LAST = 8'hC0;
  localparam logic [6:0] FRM_LAST_SF = 7'h0B;
  localparam logic [6:0] FRM_LAST_ESF = 7'h17;
  localparam logic [6:0] FRM_LAST_SLC = 7'h47;
  localparam logic [6:0] FRM_SLC_SWITCH = 7'h0C;
  localparam logic [6:0] FRM_YEL = 7'h0B;
  localparam logic [6:0] FRM_STEP_FS = 7'h04;
  localparam logic [2:0] SIG_FRM = 3'h5;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [1:0] ESF_FPS_PHASE = 2'h3;
  localparam logic [1:0] ESF_CB_PHASE = 2'h1;
  localparam logic [5:0] FS_PAT = 6'h1C;
  localparam logic [5:0] FPS_PAT = 6'h34;
  // synchronizer thresholds
  localparam logic [4:0] QUAL_SHORT = 5'h0A;
  localparam logic [4:0] QUAL_LONG = 5'h18;
  localparam logic [4:0] QUAL_MAX = 5'h1F;
  localparam logic [6:0] ZERO_RUN_LAST = 7'h7F;
  localparam logic [2:0] OOF_HITS = 3'h2;
  localparam int OOF_WIN = 5;
  localparam logic [1:0] CRC_LAST_TRY = 2'h2;
  localparam logic [5:0] CRC_POLY = 6'h03;
  // substituted codes
  localparam logic [7:0] IDLE_CODE = 8'h7F;
  localparam logic [63:0] MW_SEQ = 64'h1E0B0B1E9E8B8B9E;
  // register map
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_MARK_LOW = 3'h1;
  localparam logic [2:0] ADDR_MARK_MID = 3'h2;
  localparam logic [2:0] ADDR_MARK_HIGH = 3'h3;
  localparam logic [2:0] ADDR_STATUS = 3'h4;
  localparam logic [2:0] ADDR_OOF_CNT = 3'h5;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam int CTL_FORCE = 0;
  localparam int CTL_AUTO_DIS = 1;
  localparam int CTL_QUAL_LEN = 2;
  localparam int CTL_CROSS = 3;
  localparam int CTL_CODE_SEL = 4;
  localparam int CTL_INS_EN = 5;
  localparam int CTL_OOF_THR = 6;
  localparam int CTL_TRIG_SEL = 7;
  localparam int KIND_PRIM = 2;
  localparam int KIND_FS = 1;
  localparam int KIND_CB = 0;

  typedef enum logic [1:0] {T1RS_MODE_SF = 2'h0, T1RS_MODE_ESF = 2'h1, T1RS_MODE_SLC = 2'h2} t1rs_mode_t;
  typedef enum logic [3:0] {ST_SEARCH = 4'h1, ST_CRC = 4'h2, ST_SWITCH = 4'h4, ST_SYNC = 4'h8} t1rs_state_t;

  typedef struct packed {logic wr; logic [2:0] addr; logic [7:0] data;} t1rs_req_t;
  typedef struct packed {logic [7:0] ctrl; logic [23:0] mark; t1rs_mode_t mode; logic yel;} t1rs_cfg_t;
  typedef struct packed {
    logic realign_in_progress_pin; logic signaling_frame_marker; logic multiframe_marker;
    logic frame_marker; logic receive_serial_out; logic carrier_loss; logic yellow_alarm;
  } t1rs_rx_out_t;
  typedef struct packed {
    t1rs_cfg_t cfg; logic ftg; logic rl1; logic rl2; logic cl1; logic cl2;
    logic of1; logic of2; logic of3; logic [7:0] oof_cnt; logic [7:0] rd;
  } t1rs_host_t;
  typedef struct packed {
    logic rst1; logic rst2; t1rs_cfg_t cfg1; t1rs_cfg_t cfg2; logic ft1; logic ft2; logic ft3;
    t1rs_state_t st; logic [7:0] obit; logic [6:0] ofrm; logic [2:0] o6; logic [4:0] och;
    logic [2:0] ocb; logic [2:0] mwph; logic [7:0] nbit; logic [6:0] nfrm; logic [4:0] qual;
    logic [4:0] ferr; logic [6:0] zrun; logic [5:0] crc; logic [5:0] crc_prev; logic [5:0] cb;
    logic crc_live; logic [1:0] tries; logic pend; logic oof_tg; t1rs_rx_out_t out;
  } t1rs_link_t;

  // {primary framing bit, Fs bit, CRC bit} for a frame index
  function automatic logic [2:0] t1rs_fkind(input t1rs_mode_t m, input logic [6:0] f);
    if (m == T1RS_MODE_ESF)
      return {f[1:0] == ESF_FPS_PHASE, 1'b0, f[1:0] == ESF_CB_PHASE};
    return {!f[0], (m == T1RS_MODE_SF) && f[0], 1'b0};
  endfunction

  function automatic logic t1rs_fexp(input t1rs_mode_t m, input logic [6:0] f);
    if (m == T1RS_MODE_ESF)
      return FPS_PAT[f[4:2]];
    return f[0] ? FS_PAT[f[3:1]] : !f[1];
  endfunction

  function automatic logic [2:0] t1rs_ones(input logic [4:0] v);
    logic [2:0] n;
    n = '0;
    for (int i = 0; i < OOF_WIN; i++)
      n = n + {2'b00, v[i]};
    return n;
  endfunction
endpackage
`default_nettype wire

// [logic/t1rs_sync.sv]
// Overview of operation
// - insertion disabled ignores marks; enabled substitutes code in marked channels.
// - mark bit n of the three registers selects channel n plus one.
// - select clear inserts 7F idle; set inserts mu-law milliwatt sequence.
// - detect frame loss on Ft/FPS bits; hold realign pin high until aligned.
// - signaling frame marker forced low during realign; other timing continues.
// - switch timing at next superframe (frame 13 in 72-frame mode); pin falls early.
// - a realign leaves transmit timing and configuration untouched.
// - reset clears registers, holds timing reset, starts realign on release.
// - rising forced-realign bit starts realign at once; software re-arms by clearing.
// - disable bit blocks automatic realign; otherwise trigger bits choose conditions.
// - frame loss at 2 of 4 framing bit errors, or 2 of 5.
// - threshold also governs frame-loss reporting to the count register.
// - trigger select clear: frame loss or carrier loss; set: frame loss only.
// - qualify 10 or 24 framing bits before a multiframe edge.
// - cross-check bit meaning depends on the selected framing mode.
// - superframe, check clear: Ft alone; Fs only adjusts multiframe; declare anyway.
// - superframe, check set: Ft and Fs must both be valid.
// - S-bit yellow alarm recognised when that format is selected.
// - extended superframe, check set: three CRC attempts, then search again.
// - carrier-loss realign raises pin on the 128th consecutive zero.
`timescale 1ns/10ps
`default_nettype none
module t1rs_sync
  import t1rs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire t1rs_req_t reg_req,
  output logic [7:0] reg_rd_data,
  input wire t1rs_mode_t framing_mode,
  input wire logic sbit_yellow_sel,
  input wire logic rclk,
  input wire logic rx_data,
  output var t1rs_rx_out_t rx_out
);
  t1rs_host_t hq;
  t1rs_host_t hd;
  t1rs_link_t lq;
  t1rs_link_t ld;
  logic force_seen;
  logic [4:0] need;
  logic idle_bit;

  assign force_seen = lq.ft3 != lq.ft2;
  assign need = lq.cfg2.ctrl[CTL_QUAL_LEN] ? QUAL_LONG : QUAL_SHORT;
  assign idle_bit = IDLE_CODE[~lq.ocb];
  assign reg_rd_data = hq.rd;
  assign rx_out = lq.out;

  // host register side, clk domain
  always_comb
  begin
    hd = hq;
    hd.cfg.mode = framing_mode;
    hd.cfg.yel = sbit_yellow_sel;
    hd.rl1 = lq.out.realign_in_progress_pin;
    hd.rl2 = hq.rl1;
    hd.cl1 = lq.out.carrier_loss;
    hd.cl2 = hq.cl1;
    hd.of1 = lq.oof_tg;
    hd.of2 = hq.of1;
    hd.of3 = hq.of2;
    if (hq.of3 != hq.of2 && hq.oof_cnt != CNT_MAX)
      hd.oof_cnt = hq.oof_cnt + 8'h01;
    if (reg_req.wr)
    begin
      case (reg_req.addr)
        ADDR_CTRL:
        begin
          // only a zero-to-one write requests a realign
          if (reg_req.data[CTL_FORCE] && !hq.cfg.ctrl[CTL_FORCE])
            hd.ftg = ~hq.ftg;
          hd.cfg.ctrl = reg_req.data;
        end
        // channel n+1 sits at mark bit n
        ADDR_MARK_LOW: hd.cfg.mark[7:0] = reg_req.data;
        ADDR_MARK_MID: hd.cfg.mark[15:8] = reg_req.data;
        ADDR_MARK_HIGH: hd.cfg.mark[23:16] = reg_req.data;
        // event in the clearing cycle still counts
        ADDR_OOF_CNT: hd.oof_cnt = (hq.of3 != hq.of2) ? 8'h01 : 8'h00;
        default: hd.ftg = hq.ftg;
      endcase
    end
    case (reg_req.addr)
      ADDR_CTRL: hd.rd = hq.cfg.ctrl;
      ADDR_MARK_LOW: hd.rd = hq.cfg.mark[7:0];
      ADDR_MARK_MID: hd.rd = hq.cfg.mark[15:8];
      ADDR_MARK_HIGH: hd.rd = hq.cfg.mark[23:16];
      ADDR_STATUS: hd.rd = {6'h00, hq.cl2, hq.rl2};
      ADDR_OOF_CNT: hd.rd = hq.oof_cnt;
      default: hd.rd = 8'h00;
    endcase
    if (rst)
      hd = '0;
  end

  always_ff @(posedge clk)
    hq <= hd;

  // receive side only; no transmit state lives here
  always_comb
  begin
    logic [6:0] flast;
    logic [2:0] okind;
    logic [2:0] nkind;
    logic oexp;
    logic nexp;
    logic start;
    logic hold;
    logic [6:0] fs_step;
    flast = FRM_LAST_SF;
    start = 1'b0;
    hold = 1'b0;
    // framing bit meaning follows the common mode
    okind = t1rs_fkind(lq.cfg2.mode, lq.ofrm);
    oexp = t1rs_fexp(lq.cfg2.mode, lq.ofrm);
    nkind = t1rs_fkind(lq.cfg2.mode, lq.nfrm);
    nexp = t1rs_fexp(lq.cfg2.mode, lq.nfrm);
    fs_step = lq.nfrm + FRM_STEP_FS;
    ld = lq;
    ld.rst1 = rst;
    ld.rst2 = lq.rst1;
    // config is quasi-static; per-bit skew during a write is tolerated
    ld.cfg1 = hq.cfg;
    ld.cfg2 = lq.cfg1;
    ld.ft1 = hq.ftg;
    ld.ft2 = lq.ft1;
    ld.ft3 = lq.ft2;
    case (lq.cfg2.mode)
      T1RS_MODE_ESF: flast = FRM_LAST_ESF;
      T1RS_MODE_SLC: flast = FRM_LAST_SLC;
      default: flast = FRM_LAST_SF;
    endcase
    if (fs_step > flast)
      fs_step = fs_step - flast - 7'h01;

    // output timing free-runs in the old alignment during a realign
    if (lq.obit == BIT_LAST)
    begin
      ld.obit = '0;
      ld.ofrm = (lq.ofrm == flast) ? '0 : lq.ofrm + 7'h01;
      ld.o6 = (lq.o6 == SIG_FRM || lq.ofrm == flast) ? '0 : lq.o6 + 3'h1;
      ld.mwph = lq.mwph + 3'h1;
    end
    else
      ld.obit = lq.obit + 8'h01;
    if (lq.obit == '0)
    begin
      ld.och = '0;
      ld.ocb = '0;
    end
    else
    begin
      ld.ocb = lq.ocb + 3'h1;
      if (lq.ocb == BYTE_LAST)
        ld.och = lq.och + 5'h01;
    end

    // whole marked slot replaced, F bit never touched
    ld.out.receive_serial_out = rx_data;
    if (lq.cfg2.ctrl[CTL_INS_EN] && lq.obit != '0 && lq.cfg2.mark[lq.och])
    begin
      // idle byte or milliwatt sequence, msb first
      if (lq.cfg2.ctrl[CTL_CODE_SEL])
        ld.out.receive_serial_out = MW_SEQ[{~lq.mwph, ~lq.ocb}];
      else
        ld.out.receive_serial_out = idle_bit;
    end
    ld.out.frame_marker = lq.obit == '0;
    ld.out.multiframe_marker = lq.ofrm <= {1'b0, flast[6:1]};

    if (rx_data)
    begin
      ld.zrun = '0;
      ld.out.carrier_loss = 1'b0;
    end
    else if (lq.zrun == ZERO_RUN_LAST)
    begin
      ld.out.carrier_loss = 1'b1;
      // carrier loss triggers only with select clear
      if (!lq.out.carrier_loss && !lq.cfg2.ctrl[CTL_TRIG_SEL] && !lq.cfg2.ctrl[CTL_AUTO_DIS])
        start = 1'b1;
    end
    else
      ld.zrun = lq.zrun + 7'h01;

    // frame loss watched on Ft/FPS bits only
    if (lq.st == ST_SYNC && lq.obit == '0 && okind[KIND_PRIM])
    begin
      ld.ferr = {lq.ferr[3:0], rx_data != oexp};
      // 2 of 4 or 2 of 5 window
      if (t1rs_ones(lq.cfg2.ctrl[CTL_OOF_THR] ? ld.ferr : {1'b0, ld.ferr[3:0]}) >= OOF_HITS)
      begin
        ld.ferr = '0;
        ld.oof_tg = ~lq.oof_tg;
        if (!lq.cfg2.ctrl[CTL_AUTO_DIS])
          start = 1'b1;
      end
    end
    // yellow carried in the frame-12 S bit
    if (lq.st == ST_SYNC && lq.obit == '0 && okind[KIND_FS] && lq.ofrm == FRM_YEL && lq.cfg2.yel)
      ld.out.yellow_alarm = rx_data;

    // candidate alignment counters
    if (lq.nbit == BIT_LAST)
    begin
      ld.nbit = '0;
      ld.nfrm = (lq.nfrm == flast) ? '0 : lq.nfrm + 7'h01;
    end
    else
      ld.nbit = lq.nbit + 8'h01;
    if (lq.nbit != '0)
      ld.crc = {lq.crc[4:0], 1'b0} ^ ((lq.crc[5] ^ rx_data) ? CRC_POLY : 6'h00);

    case (lq.st)
      ST_SEARCH:
        if (lq.nbit == '0)
        begin
          if (nkind[KIND_PRIM])
          begin
            if (rx_data == nexp)
              ld.qual = (lq.qual == QUAL_MAX) ? lq.qual : lq.qual + 5'h01;
            else
              hold = 1'b1;
          end
          else if (nkind[KIND_FS] && !(lq.cfg2.yel && lq.nfrm == FRM_YEL) && rx_data != nexp)
          begin
            if (lq.cfg2.ctrl[CTL_CROSS])
              hold = 1'b1;
            // Fs only moves the multiframe phase
            else
              ld.nfrm = fs_step;
          end
          if (hold)
          begin
            ld.nbit = lq.nbit;
            ld.nfrm = lq.nfrm;
            ld.qual = '0;
          end
          // enough framing bits ahead of the multiframe edge
          else if (lq.nfrm == '0 && lq.qual >= need)
          begin
            ld.st = (lq.cfg2.mode == T1RS_MODE_ESF && lq.cfg2.ctrl[CTL_CROSS]) ? ST_CRC : ST_SWITCH;
            ld.tries = '0;
            ld.crc_live = 1'b0;
          end
        end
      ST_CRC:
        if (lq.nbit == '0)
        begin
          if (nkind[KIND_CB])
            ld.cb = {lq.cb[4:0], rx_data};
          if (lq.nfrm == '0)
          begin
            ld.crc_prev = lq.crc;
            ld.crc = '0;
            ld.crc_live = 1'b1;
            if (lq.crc_live)
            begin
              if (lq.cb == lq.crc_prev)
                ld.st = ST_SWITCH;
              else if (lq.tries == CRC_LAST_TRY)
              begin
                ld.st = ST_SEARCH;
                ld.qual = '0;
              end
              else
                ld.tries = lq.tries + 2'h1;
            end
          end
        end
      ST_SWITCH:
        // adopt new alignment at superframe start
        if (lq.nbit == '0 && lq.nfrm == ((lq.cfg2.mode == T1RS_MODE_SLC) ? FRM_SLC_SWITCH : 7'h00))
        begin
          ld.obit = 8'h01;
          ld.ofrm = lq.nfrm;
          ld.o6 = '0;
          ld.och = '0;
          ld.ocb = '0;
          ld.ferr = '0;
          ld.pend = 1'b1;
          ld.st = ST_SYNC;
        end
      ST_SYNC:
        // pin drops one bit before the second frame's F bit
        if (lq.pend && lq.obit == BIT_LAST)
        begin
          ld.pend = 1'b0;
          ld.out.realign_in_progress_pin = 1'b0;
        end
      default: ld.st = ST_SEARCH;
    endcase

    // forced realign ignores the disable bit
    if (start || force_seen)
    begin
      ld.st = ST_SEARCH;
      ld.qual = '0;
      ld.pend = 1'b0;
      ld.ferr = '0;
      ld.out.realign_in_progress_pin = 1'b1;
    end
    ld.out.signaling_frame_marker = (lq.o6 == SIG_FRM) && !ld.out.realign_in_progress_pin;

    // timing held at zero, realign pending on release
    if (lq.rst2)
      ld = '{rst1: ld.rst1, rst2: ld.rst2, cfg1: ld.cfg1, cfg2: ld.cfg2, ft1: ld.ft1, ft2: ld.ft2, ft3: ld.ft3,
        st: ST_SEARCH, out: '{realign_in_progress_pin: 1'b1, default: 1'b0}, default: '0};
  end

  always_ff @(posedge rclk)
    lq <= ld;

  a_ins_off_pass: assert property (@(posedge rclk) disable iff (lq.rst2)
    !lq.cfg2.ctrl[CTL_INS_EN] |=> rx_out.receive_serial_out == $past(rx_data))
    else $error("insertion active while disabled");
  a_idle_code: assert property (@(posedge rclk) disable iff (lq.rst2)
    (lq.cfg2.ctrl[CTL_INS_EN] && !lq.cfg2.ctrl[CTL_CODE_SEL] && lq.obit != '0 && lq.cfg2.mark[lq.och])
    |=> rx_out.receive_serial_out == $past(idle_bit))
    else $error("idle code bit wrong");
  a_sig_low_resync: assert property (@(posedge rclk) disable iff (lq.rst2)
    rx_out.realign_in_progress_pin |-> !rx_out.signaling_frame_marker)
    else $error("signaling marker high during realign");
  a_auto_off: assert property (@(posedge rclk) disable iff (lq.rst2)
    $rose(rx_out.realign_in_progress_pin) |-> $past(force_seen) || !$past(lq.cfg2.ctrl[CTL_AUTO_DIS]))
    else $error("self-started realign while disabled");
  a_force_start: assert property (@(posedge rclk) disable iff (lq.rst2)
    force_seen |=> rx_out.realign_in_progress_pin && lq.st == ST_SEARCH)
    else $error("forced realign not started");
  a_closs_128: assert property (@(posedge rclk) disable iff (lq.rst2)
    $rose(rx_out.carrier_loss) |-> $past(lq.zrun) == ZERO_RUN_LAST && !$past(rx_data))
    else $error("carrier loss not on 128th zero");
  a_realign_in_progress_pin_fall: assert property (@(posedge rclk) disable iff (lq.rst2)
    $fell(rx_out.realign_in_progress_pin) |-> lq.obit == '0 && lq.st == ST_SYNC && $past(lq.pend))
    else $error("realign pin fell at wrong bit");
  a_qual_len: assert property (@(posedge rclk) disable iff (lq.rst2)
    (lq.st == ST_SEARCH && !force_seen ##1 lq.st != ST_SEARCH) |-> $past(lq.qual) >= $past(need))
    else $error("alignment declared too early");
  a_crc_tries: assert property (@(posedge rclk) disable iff (lq.rst2)
    (lq.st == ST_CRC && lq.tries == CRC_LAST_TRY && lq.crc_live && lq.nbit == '0 && lq.nfrm == '0
     && lq.cb != lq.crc_prev && !force_seen) |=> lq.st == ST_SEARCH)
    else $error("fourth CRC attempt allowed");
  a_force_toggle: assert property (@(posedge clk) disable iff (rst)
    (reg_req.wr && reg_req.addr == ADDR_CTRL && reg_req.data[CTL_FORCE] && !hq.cfg.ctrl[CTL_FORCE])
    |=> hq.ftg != $past(hq.ftg))
    else $error("forced realign request lost");

  c_realign_done: cover property (@(posedge rclk) disable iff (lq.rst2) $fell(rx_out.realign_in_progress_pin));
  c_milliwatt: cover property (@(posedge rclk) disable iff (lq.rst2)
    lq.cfg2.ctrl[CTL_INS_EN] && lq.cfg2.ctrl[CTL_CODE_SEL] && lq.cfg2.mark[lq.och] && lq.obit != '0);
  c_carrier_loss: cover property (@(posedge rclk) disable iff (lq.rst2) $rose(rx_out.carrier_loss));
  c_crc_check: cover property (@(posedge rclk) disable iff (lq.rst2) lq.st == ST_CRC ##1 lq.st == ST_SWITCH);
endmodule
`default_nettype wire

// [verif/t1rs_line_model.sv]
`timescale 1ns/10ps
`default_nettype none
module t1rs_line_model
  import t1rs_pkg::*;
(
  input wire logic rclk,
  input wire logic rst,
  input wire logic zeros,
  input wire logic bad,
  output logic rx_data,
  output logic [7:0] bit_idx,
  output logic [6:0] frm_idx
);
  logic [15:0] lfsr_q = 16'hACE1;
  logic [7:0] nb_q = 8'h00;
  logic [6:0] nf_q = 7'h00;
  logic [3:0] ft_q = 4'h0;
  logic r1_q = 1'b1;
  logic fb;
  initial rx_data = 1'b0;
  initial bit_idx = 8'h00;
  initial frm_idx = 7'h00;
  // terminal bits on even frames, signaling bits on odd frames
  assign fb = nf_q[0] ? FS_PAT[nf_q[3:1]] : ~nf_q[1];
  always @(posedge rclk)
  begin
    lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    bit_idx <= nb_q;
    frm_idx <= nf_q;
    if (nb_q == 8'h00 && !nf_q[0])
      ft_q <= ft_q + 4'h1;
    // line goes quiet: carrier loss as a run of zeros
    if (zeros)
      rx_data <= 1'b0;
    // every fourth terminal bit inverted, spacing only 2-of-5 catches
    else if (nb_q == 8'h00)
      rx_data <= fb ^ (bad && !nf_q[0] && ft_q[1:0] == 2'h0);
    else
      rx_data <= lfsr_q[0];
    nb_q <= (nb_q == BIT_LAST) ? 8'h00 : nb_q + 8'h01;
    if (nb_q == BIT_LAST)
      nf_q <= (nf_q == FRM_LAST_SF) ? 7'h00 : nf_q + 7'h01;
    // line starts its frame 0 as the receiver leaves reset, same crossing
    r1_q <= rst;
    if (r1_q)
    begin
      nb_q <= 8'h00;
      nf_q <= 7'h00;
    end
  end
endmodule
`default_nettype wire

// [verif/t1_receive_sync_control_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module t1_receive_sync_control_tb;
  import t1rs_pkg::*;
  logic clk = 1'b0;
  logic rclk = 1'b0;
  logic rst = 1'b1;
  t1rs_req_t reg_req = '0;
  logic [7:0] reg_rd_data;
  t1rs_rx_out_t rx_out;
  logic rx_data;
  logic zeros = 1'b0;
  logic bad = 1'b0;
  logic [7:0] bit_idx;
  logic [6:0] frm_idx;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  int zc = 0;
  logic [31:0] seed = 32'h4C78;
  logic [7:0] ctrl_m = 8'h00;
  logic [23:0] mark_m = 24'h000000;
  logic chk = 1'b0;
  logic pin_seen = 1'b0;
  logic cl_q = 1'b0;
  logic exp_b = 1'b0;
  logic [7:0] exp_i = 8'h00;
  logic [6:0] exp_f = 7'h00;
  logic [2:0] mw_ph = 3'h0;
  logic [7:0] got_by = 8'h00;
  logic [7:0] raw_by = 8'h00;
  logic [7:0] cl_ctl [0:2] = '{8'h02, 8'h80, 8'h00};
  logic [7:0] ins_ctl [0:2] = '{8'h20, 8'h30, 8'h10};

  always #2.5 clk = ~clk;
  always #3 rclk = ~rclk;

  t1rs_sync t1rs_sync_i (.clk(clk), .rst(rst), .reg_req(reg_req), .reg_rd_data(reg_rd_data),
    .framing_mode(T1RS_MODE_SF), .sbit_yellow_sel(1'b0), .rclk(rclk), .rx_data(rx_data), .rx_out(rx_out));
  t1rs_line_model t1rs_line_model_i (.rclk(rclk), .rst(rst), .zeros(zeros), .bad(bad), .rx_data(rx_data),
    .bit_idx(bit_idx), .frm_idx(frm_idx));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic fail(input string msg);
    miscompares++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask
  task automatic cmp1(input logic got, input logic e, input string msg);
    total_checks++;
    if (got !== e) fail(msg);
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] e, input string msg);
    total_checks++;
    if (got !== e) fail(msg);
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk) reg_req <= '{1'b1, a, d};
    @(posedge clk) reg_req.wr <= 1'b0;
    if (a == ADDR_CTRL) ctrl_m = d;
    if (a >= ADDR_MARK_LOW && a <= ADDR_MARK_HIGH) mark_m[8*(a-1)+:8] = d;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk) reg_req.addr <= a;
    repeat (2) @(posedge clk);
    #1 cmp8(reg_rd_data, e, "register read");
  endtask
  task automatic wait_pin(input logic v, input int lim);
    for (int i = 0; i < lim && rx_out.realign_in_progress_pin !== v; i++)
      @(posedge clk);
    cmp1(rx_out.realign_in_progress_pin, v, "realign pin");
  endtask

  // milliwatt byte follows output frames counted since reset
  task automatic chk_byte(input int ch);
    logic [7:0] e;
    e = raw_by;
    if (ctrl_m[CTL_INS_EN] && mark_m[ch])
      e = ctrl_m[CTL_CODE_SEL] ? MW_SEQ[8*(7-mw_ph)+:8] : IDLE_CODE;
    cmp8(got_by, e, "channel byte");
  endtask

  always @(posedge rclk)
  begin
    exp_b <= rx_data;
    exp_i <= bit_idx;
    exp_f <= frm_idx;
    if (exp_i == BIT_LAST) mw_ph <= mw_ph + 3'h1;
    zc <= (rx_data === 1'b0) ? zc + 1 : 0;
    cl_q <= rx_out.carrier_loss;
    got_by = {got_by[6:0], rx_out.receive_serial_out};
    raw_by = {raw_by[6:0], exp_b};
    if (rx_out.realign_in_progress_pin === 1'b1)
    begin
      pin_seen <= 1'b1;
      cmp1(rx_out.signaling_frame_marker, 1'b0, "signaling marker in realign");
    end
    if (chk && rx_out.realign_in_progress_pin === 1'b0)
    begin
      cmp1(rx_out.frame_marker, exp_i == 8'h00, "frame marker");
      cmp1(rx_out.multiframe_marker, exp_f <= {1'b0, FRM_LAST_SF[6:1]}, "multiframe marker");
      cmp1(rx_out.signaling_frame_marker, exp_f == 7'h05 || exp_f == 7'h0B, "signaling marker");
      if (exp_i != 8'h00 && exp_i[2:0] == 3'h0) chk_byte(exp_i[7:3] - 1);
    end
    if (rx_out.carrier_loss === 1'b1 && cl_q === 1'b0)
    begin
      cmp1(zc >= 128 && zc <= 130, 1'b1, "zero run length");
      cmp1(rx_out.realign_in_progress_pin, !ctrl_m[CTL_AUTO_DIS] && !ctrl_m[CTL_TRIG_SEL], "loss trigger");
    end
  end

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 99000)
    begin
      fail("timeout");
      report_and_stop();
    end
  end

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rdc(a[2:0], (a == 4) ? 8'h01 : 8'h00);
    for (int a = 1; a < 4; a++)
    begin
      seed = xs(seed);
      wr(a[2:0], seed[7:0]);
      rdc(a[2:0], seed[7:0]);
    end
    wr(3'h6, 8'hFF);
    rdc(3'h6, 8'h00);
    done("registers");
    wait_pin(1'b0, 70000);
    for (int k = 0; k < 3; k++)
    begin
      chk = 1'b0;
      wr(ADDR_CTRL, ins_ctl[k]);
      repeat (40) @(posedge rclk);
      chk = 1'b1;
      repeat (800) @(posedge rclk);
    end
    chk = 1'b0;
    done("insertion");
    wr(ADDR_CTRL, 8'h01);
    wait_pin(1'b1, 100);
    wait_pin(1'b0, 30000);
    pin_seen = 1'b0;
    wr(ADDR_CTRL, 8'h01);
    repeat (2000) @(posedge clk);
    cmp1(pin_seen, 1'b0, "realign without rising bit");
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CTRL, 8'h01);
    wait_pin(1'b1, 100);
    wait_pin(1'b0, 30000);
    done("forced realign");
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_OOF_CNT, 8'h00);
    pin_seen = 1'b0;
    bad <= 1'b1;
    repeat (4700) @(posedge clk);
    cmp1(pin_seen, 1'b0, "loss under 2 of 4");
    rdc(ADDR_OOF_CNT, 8'h00);
    wr(ADDR_CTRL, 8'h40);
    wait_pin(1'b1, 4000);
    bad <= 1'b0;
    rdc(ADDR_OOF_CNT, 8'h01);
    wait_pin(1'b0, 30000);
    done("loss threshold");
    for (int k = 0; k < 3; k++)
    begin
      wr(ADDR_CTRL, cl_ctl[k]);
      repeat (30) @(posedge clk);
      zeros <= 1'b1;
      repeat (150) @(posedge rclk);
      #1 cmp1(rx_out.carrier_loss, 1'b1, "carrier loss");
      @(posedge clk) zeros <= 1'b0;
      repeat (10) @(posedge rclk);
      #1 cmp1(rx_out.carrier_loss, 1'b0, "carrier back");
      wait_pin(1'b0, 30000);
      // let a framing error from the quiet line age out of the loss window
      repeat (2000) @(posedge rclk);
    end
    done("carrier loss");
    report_and_stop();
  end
endmodule
`default_nettype wire
